/* File: logic/ats_pkg.sv */
package ats_pkg;
    localparam int DATA_W = 8;
    localparam int PRESC_W = 10;
    localparam int NUM_PATHS = 3;
    localparam int IDX_COUNT = 0;
    localparam int IDX_COMPARE = 1;
    localparam int IDX_CONTROL = 2;
    localparam logic [1:0] XFER_EDGES = 2'h2;
    localparam int FLAG_SYNC_STAGES = 3;
    localparam logic [2:0] STALL_CYCLES = 3'h4;
    localparam logic [2:0] STALL_ZERO = 3'h0;
    localparam logic [2:0] STALL_ONE = 3'h1;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_ONE = 10'h001;
    localparam logic [PRESC_W-1:0] PRESC_ZERO = 10'h000;
    localparam logic [1:0] EDGE_ONE = 2'h1;
    localparam logic [1:0] EDGE_ZERO = 2'h0;
    // Control field positions
    localparam int CS_LSB = 0;
    localparam int CS_MSB = 2;
    localparam int COM_LSB = 4;
    localparam int COM_MSB = 5;
    // Clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV32 = 3'h3;
    localparam logic [2:0] CS_DIV64 = 3'h4;
    localparam logic [2:0] CS_DIV128 = 3'h5;
    localparam logic [2:0] CS_DIV256 = 3'h6;
    localparam logic [2:0] CS_DIV1024 = 3'h7;
    // Prescaler tap masks: tick when all masked bits are ones
    localparam logic [PRESC_W-1:0] MASK_DIV8 = 10'h007;
    localparam logic [PRESC_W-1:0] MASK_DIV32 = 10'h01f;
    localparam logic [PRESC_W-1:0] MASK_DIV64 = 10'h03f;
    localparam logic [PRESC_W-1:0] MASK_DIV128 = 10'h07f;
    localparam logic [PRESC_W-1:0] MASK_DIV256 = 10'h0ff;
    localparam logic [PRESC_W-1:0] MASK_DIV1024 = 10'h3ff;
    // Compare output modes
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef enum logic [1:0] {
        WK_IDLE,
        WK_PENDING,
        WK_STALL,
        WK_DISPATCH
    } ats_wake_e;

    typedef struct packed {
        logic [NUM_PATHS-1:0][DATA_W-1:0] tmp;
        logic [NUM_PATHS-1:0] busy;
        logic [NUM_PATHS-1:0][1:0] edges;
        logic [NUM_PATHS-1:0][DATA_W-1:0] dest;
        logic [PRESC_W-1:0] presc;
        logic osc_prev;
        logic [DATA_W-1:0] shadow;
        logic match_block;
        logic [FLAG_SYNC_STAGES-1:0] cmp_pipe;
        logic [FLAG_SYNC_STAGES-1:0] ovf_pipe;
        logic cmp_flag;
        logic ovf_flag;
        logic cmp_out;
        ats_wake_e wake;
        logic [2:0] stall_cnt;
        logic armed;
        logic wake_pulse;
        logic dispatch;
        logic pd_prev;
        logic regs_lost;
    } ats_state_s;
endpackage

/* File: logic/ats_timer.sv */
`timescale 1ns/100ps
// Behaviour
// - Tick enables I/O clock or oscillator edges
// - Async writes land after two oscillator edges
// - Separate holding register per destination
// - Busy flags show pending transfers
// - No compare match during count/compare update
// - Wake logic re-arms on next oscillator rise (timer tick in sync mode)
// - Oscillator runs with async clock select, except in power-down
// - Registers undefined after power-down wake
// - Wake starts on next timer tick
// - Stall four cycles then dispatch interrupt
// - Counter read via shadow refreshed on edges
// - Shadow holds pre-sleep value until edge
// - Async flags arrive three cycles after tick
// - Compare pin changes on timer tick
// - Default I/O clock; select detaches pins
// - Prescaler offers stop, 1, 8..1024
// - Prescaler reset bit restarts prescaler
// - Count busy sets on write, clears on copy
// - Clock select field code mapping
module ats_timer
    import ats_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic ASYNC_CLOCK_SELECT,
    input wire logic OSC_INPUT_PIN,
    input wire logic PRESCALER_RESET_BIT,
    input wire logic COUNT_WR,
    input wire logic [7:0] COUNT_WDATA,
    input wire logic COMPARE_WR,
    input wire logic [7:0] COMPARE_WDATA,
    input wire logic CONTROL_WR,
    input wire logic [7:0] CONTROL_WDATA,
    input wire logic COMPARE_IRQ_ENABLE,
    input wire logic OVERFLOW_IRQ_ENABLE,
    input wire logic COMPARE_FLAG_CLEAR,
    input wire logic OVERFLOW_FLAG_CLEAR,
    input wire logic SLEEP_POWER_SAVE,
    input wire logic SLEEP_POWER_DOWN,
    output logic [7:0] TIMER_COUNT_VALUE,
    output logic [7:0] TIMER_COMPARE_VALUE,
    output logic [7:0] TIMER_CONTROL_REG,
    output logic COUNT_UPDATE_BUSY,
    output logic COMPARE_UPDATE_BUSY,
    output logic CONTROL_UPDATE_BUSY,
    output logic COMPARE_MATCH_FLAG,
    output logic OVERFLOW_FLAG,
    output logic COMPARE_OUTPUT_PIN,
    output logic OSC_ENABLE,
    output logic OSC_PINS_DETACHED,
    output logic WAKE_REQUEST,
    output logic CPU_STALL,
    output logic IRQ_DISPATCH,
    output logic REGS_LOST
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    ats_state_s s_q;
    ats_state_s s_d;

    logic osc_en;
    logic osc_rise;
    logic src_tick;
    logic timer_tick;
    logic [2:0] clk_sel;
    logic [1:0] com_mode;
    logic [PRESC_W-1:0] tap_mask;
    logic tap_hit;
    logic [NUM_PATHS-1:0] wr;
    logic [NUM_PATHS-1:0][DATA_W-1:0] wdata;
    logic cmp_event;
    logic ovf_event;
    logic cmp_set;
    logic ovf_set;
    logic irq_cond;

    // Reset release through two flops
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign wr = {CONTROL_WR, COMPARE_WR, COUNT_WR};
    assign wdata = {CONTROL_WDATA, COMPARE_WDATA, COUNT_WDATA};
    assign clk_sel = s_q.dest[IDX_CONTROL][CS_MSB:CS_LSB];
    assign com_mode = s_q.dest[IDX_CONTROL][COM_MSB:COM_LSB];

    assign osc_en = ASYNC_CLOCK_SELECT && !SLEEP_POWER_DOWN;
    assign osc_rise = osc_en && OSC_INPUT_PIN && !s_q.osc_prev;
    // Source tick: every I/O clock outside power-save and power-down, or each oscillator rise
    always_comb begin
        if (ASYNC_CLOCK_SELECT) begin
            src_tick = osc_rise;
        end else begin
            src_tick = !SLEEP_POWER_SAVE && !SLEEP_POWER_DOWN;
        end
    end

    always_comb begin
        unique case (clk_sel)
            CS_STOP: tap_mask = PRESC_ZERO;
            CS_DIV1: tap_mask = PRESC_ZERO;
            CS_DIV8: tap_mask = MASK_DIV8;
            CS_DIV32: tap_mask = MASK_DIV32;
            CS_DIV64: tap_mask = MASK_DIV64;
            CS_DIV128: tap_mask = MASK_DIV128;
            CS_DIV256: tap_mask = MASK_DIV256;
            CS_DIV1024: tap_mask = MASK_DIV1024;
        endcase
    end
    assign tap_hit = (s_q.presc & tap_mask) == tap_mask;
    assign timer_tick = src_tick && tap_hit && (clk_sel != CS_STOP);

    // Match needs no pending count or compare update
    assign cmp_event = timer_tick
        && (s_q.dest[IDX_COUNT] == s_q.dest[IDX_COMPARE])
        && !s_q.busy[IDX_COUNT] && !s_q.busy[IDX_COMPARE]
        && !s_q.match_block;
    assign ovf_event = timer_tick && (s_q.dest[IDX_COUNT] == COUNT_MAX);

    // Async flags pass three CPU stages after the tick
    assign cmp_set = ASYNC_CLOCK_SELECT ?
        s_q.cmp_pipe[FLAG_SYNC_STAGES-1] : cmp_event;
    assign ovf_set = ASYNC_CLOCK_SELECT ?
        s_q.ovf_pipe[FLAG_SYNC_STAGES-1] : ovf_event;
    assign irq_cond = (cmp_event && COMPARE_IRQ_ENABLE)
        || (ovf_event && OVERFLOW_IRQ_ENABLE);

    always_comb begin
        s_d = s_q;
        s_d.wake_pulse = 1'b0;
        s_d.dispatch = 1'b0;
        s_d.osc_prev = OSC_INPUT_PIN && osc_en;

        if (PRESCALER_RESET_BIT) begin
            s_d.presc = PRESC_ZERO;
        end else if (src_tick) begin
            s_d.presc = s_q.presc + PRESC_ONE;
        end

        if (timer_tick) begin
            s_d.dest[IDX_COUNT] = s_q.dest[IDX_COUNT] + COUNT_ONE;
            s_d.match_block = 1'b0;
        end

        if (cmp_event) begin
            unique case (com_mode)
                COM_OFF: s_d.cmp_out = s_q.cmp_out;
                COM_TOGGLE: s_d.cmp_out = !s_q.cmp_out;
                COM_CLEAR: s_d.cmp_out = 1'b0;
                COM_SET: s_d.cmp_out = 1'b1;
            endcase
        end

        // Holding register and busy per destination
        for (int i = 0; i < NUM_PATHS; i++) begin
            if (s_q.busy[i] && osc_rise) begin
                s_d.edges[i] = s_q.edges[i] + EDGE_ONE;
                if (s_q.edges[i] + EDGE_ONE == XFER_EDGES) begin
                    s_d.dest[i] = s_q.tmp[i];
                    s_d.busy[i] = 1'b0;
                end
            end
            if (wr[i]) begin
                if (ASYNC_CLOCK_SELECT) begin
                    s_d.tmp[i] = wdata[i];
                    s_d.busy[i] = 1'b1;
                    s_d.edges[i] = EDGE_ZERO;
                end else begin
                    s_d.dest[i] = wdata[i];
                end
            end
        end
        if (COUNT_WR) begin
            s_d.match_block = 1'b1;
        end

        // Shadow: per oscillator rise in async mode, else every cycle outside power-save
        if (ASYNC_CLOCK_SELECT) begin
            if (osc_rise) begin
                s_d.shadow = s_q.dest[IDX_COUNT];
            end
        end else if (!SLEEP_POWER_SAVE) begin
            s_d.shadow = s_q.dest[IDX_COUNT];
        end

        s_d.cmp_pipe = {s_q.cmp_pipe[FLAG_SYNC_STAGES-2:0], cmp_event};
        s_d.ovf_pipe = {s_q.ovf_pipe[FLAG_SYNC_STAGES-2:0], ovf_event};
        // Set wins over clear
        s_d.cmp_flag = cmp_set || (s_q.cmp_flag && !COMPARE_FLAG_CLEAR);
        s_d.ovf_flag = ovf_set || (s_q.ovf_flag && !OVERFLOW_FLAG_CLEAR);

        unique case (s_q.wake)
            WK_IDLE: begin
                if (SLEEP_POWER_SAVE && s_q.armed && irq_cond) begin
                    s_d.wake = WK_PENDING;
                end
            end
            WK_PENDING: begin
                if (timer_tick) begin
                    s_d.wake = WK_STALL;
                    s_d.wake_pulse = 1'b1;
                    s_d.stall_cnt = STALL_CYCLES;
                    s_d.armed = 1'b0;
                end
            end
            WK_STALL: begin
                s_d.stall_cnt = s_q.stall_cnt - STALL_ONE;
                if (s_q.stall_cnt == STALL_ONE) begin
                    s_d.wake = WK_DISPATCH;
                end
            end
            WK_DISPATCH: begin
                s_d.dispatch = 1'b1;
                s_d.wake = WK_IDLE;
            end
        endcase
        // Re-arm on the next oscillator rise, or on a timer tick without async clock
        if (!s_q.armed && s_q.wake == WK_IDLE
            && (ASYNC_CLOCK_SELECT ? osc_rise : timer_tick)) begin
            s_d.armed = 1'b1;
        end

        s_d.pd_prev = SLEEP_POWER_DOWN;
        if (s_q.pd_prev && !SLEEP_POWER_DOWN) begin
            s_d.regs_lost = 1'b1;
        end else if (|wr) begin
            s_d.regs_lost = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_q.tmp <= '0;
            s_q.busy <= '0;
            s_q.edges <= '0;
            s_q.dest[IDX_COUNT] <= COUNT_RESET;
            s_q.dest[IDX_COMPARE] <= COMPARE_RESET;
            s_q.dest[IDX_CONTROL] <= CTRL_RESET;
            s_q.presc <= PRESC_ZERO;
            s_q.osc_prev <= 1'b0;
            s_q.shadow <= COUNT_RESET;
            s_q.match_block <= 1'b0;
            s_q.cmp_pipe <= '0;
            s_q.ovf_pipe <= '0;
            s_q.cmp_flag <= 1'b0;
            s_q.ovf_flag <= 1'b0;
            s_q.cmp_out <= 1'b0;
            s_q.wake <= WK_IDLE;
            s_q.stall_cnt <= STALL_ZERO;
            s_q.armed <= 1'b1;
            s_q.wake_pulse <= 1'b0;
            s_q.dispatch <= 1'b0;
            s_q.pd_prev <= 1'b0;
            s_q.regs_lost <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign TIMER_COUNT_VALUE = s_q.shadow;
    assign TIMER_COMPARE_VALUE = s_q.dest[IDX_COMPARE];
    assign TIMER_CONTROL_REG = s_q.dest[IDX_CONTROL];
    assign COUNT_UPDATE_BUSY = s_q.busy[IDX_COUNT];
    assign COMPARE_UPDATE_BUSY = s_q.busy[IDX_COMPARE];
    assign CONTROL_UPDATE_BUSY = s_q.busy[IDX_CONTROL];
    assign COMPARE_MATCH_FLAG = s_q.cmp_flag;
    assign OVERFLOW_FLAG = s_q.ovf_flag;
    assign COMPARE_OUTPUT_PIN = s_q.cmp_out;
    assign OSC_ENABLE = osc_en;
    assign OSC_PINS_DETACHED = ASYNC_CLOCK_SELECT;
    assign WAKE_REQUEST = s_q.wake_pulse;
    assign CPU_STALL = (s_q.wake == WK_STALL);
    assign IRQ_DISPATCH = s_q.dispatch;
    assign REGS_LOST = s_q.regs_lost;
endmodule

/* File: test/ats_osc_model.sv */
`timescale 1ns/100ps
module ats_osc_model (
    input wire logic en,
    output logic osc
);
    // Ten CPU cycles a period, kept off the CLK edges; still while disabled
    initial begin
        osc = 1'b0;
        #13;
        forever begin
            #250;
            osc = en ? ~osc : 1'b0;
        end
    end
endmodule

/* File: test/ats_timer_properties.sv */
`timescale 1ns/100ps
module ats_timer_chk (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic ASYNC_CLOCK_SELECT,
    input wire logic OSC_INPUT_PIN,
    input wire logic COUNT_WR,
    input wire logic COMPARE_WR,
    input wire logic [7:0] COMPARE_WDATA,
    input wire logic SLEEP_POWER_DOWN,
    input wire logic [7:0] TIMER_COMPARE_VALUE,
    input wire logic [7:0] TIMER_CONTROL_REG,
    input wire logic COUNT_UPDATE_BUSY,
    input wire logic COMPARE_UPDATE_BUSY,
    input wire logic CONTROL_UPDATE_BUSY,
    input wire logic OSC_ENABLE,
    input wire logic OSC_PINS_DETACHED,
    input wire logic WAKE_REQUEST,
    input wire logic CPU_STALL,
    input wire logic IRQ_DISPATCH,
    input wire logic REGS_LOST
);
    localparam int BUSY_MAX = 30;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence osc_rose_s;
        $past(OSC_INPUT_PIN) && !$past(OSC_INPUT_PIN, 2);
    endsequence
    sequence stall_run_s;
        CPU_STALL [*4] ##1 !CPU_STALL ##1 IRQ_DISPATCH;
    endsequence
    osc_gate_a: assert property (
        OSC_ENABLE == (ASYNC_CLOCK_SELECT && !SLEEP_POWER_DOWN))
        else $error("oscillator enable wrong");
    pin_detach_a: assert property (
        OSC_PINS_DETACHED == ASYNC_CLOCK_SELECT)
        else $error("pin detach wrong");
    sync_write_a: assert property (
        !ASYNC_CLOCK_SELECT && COMPARE_WR
        |=> TIMER_COMPARE_VALUE == $past(COMPARE_WDATA))
        else $error("sync compare write lost");
    count_busy_a: assert property (
        ASYNC_CLOCK_SELECT && COUNT_WR |=> COUNT_UPDATE_BUSY)
        else $error("count busy not set");
    cmp_busy_hold_a: assert property (
        ASYNC_CLOCK_SELECT && COMPARE_WR |=> COMPARE_UPDATE_BUSY [*4])
        else $error("compare busy too short");
    busy_drop_a: assert property (
        $fell(COUNT_UPDATE_BUSY) |-> osc_rose_s)
        else $error("count busy cleared off an oscillator rise");
    ctrl_hold_a: assert property (
        CONTROL_UPDATE_BUSY && $past(CONTROL_UPDATE_BUSY)
        |-> $stable(TIMER_CONTROL_REG))
        else $error("control changed while pending");
    busy_bound_a: assert property (
        $rose(CONTROL_UPDATE_BUSY) |-> ##[1:BUSY_MAX] !CONTROL_UPDATE_BUSY)
        else $error("control busy stuck");
    wake_stall_a: assert property (
        $rose(WAKE_REQUEST) |-> ##[0:2] CPU_STALL)
        else $error("no stall after wake");
    stall_len_a: assert property (
        $rose(CPU_STALL) |-> stall_run_s)
        else $error("stall length or dispatch wrong");
    regs_lost_a: assert property (
        $fell(SLEEP_POWER_DOWN) |-> ##[1:2] REGS_LOST)
        else $error("lost flag not set");
endmodule

bind ats_timer ats_timer_chk u_chk (
    .CLK, .RESETN, .ASYNC_CLOCK_SELECT, .OSC_INPUT_PIN, .COUNT_WR,
    .COMPARE_WR, .COMPARE_WDATA, .SLEEP_POWER_DOWN, .TIMER_COMPARE_VALUE,
    .TIMER_CONTROL_REG, .COUNT_UPDATE_BUSY, .COMPARE_UPDATE_BUSY,
    .CONTROL_UPDATE_BUSY, .OSC_ENABLE, .OSC_PINS_DETACHED, .WAKE_REQUEST,
    .CPU_STALL, .IRQ_DISPATCH, .REGS_LOST
);

/* File: test/tb.sv */
`timescale 1ns/100ps
module tb;
    logic CLK = 1'b0;
    logic RESETN, ASYNC_CLOCK_SELECT, OSC_INPUT_PIN, PRESCALER_RESET_BIT;
    logic COUNT_WR, COMPARE_WR, CONTROL_WR, COMPARE_IRQ_ENABLE;
    logic OVERFLOW_IRQ_ENABLE, COMPARE_FLAG_CLEAR, OVERFLOW_FLAG_CLEAR;
    logic SLEEP_POWER_SAVE, SLEEP_POWER_DOWN, COMPARE_MATCH_FLAG;
    logic [7:0] COUNT_WDATA, COMPARE_WDATA, CONTROL_WDATA, TIMER_COUNT_VALUE;
    logic [7:0] TIMER_COMPARE_VALUE, TIMER_CONTROL_REG, d1, d2;
    logic COUNT_UPDATE_BUSY, COMPARE_UPDATE_BUSY, CONTROL_UPDATE_BUSY;
    logic COMPARE_OUTPUT_PIN, OSC_ENABLE, OSC_PINS_DETACHED, WAKE_REQUEST;
    logic CPU_STALL, IRQ_DISPATCH, REGS_LOST, OVERFLOW_FLAG;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int k, c0, st;
    int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic [1:0] modes[6] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h3, 2'h1};
    logic pins[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

    ats_timer dut (
        .CLK, .RESETN, .ASYNC_CLOCK_SELECT, .OSC_INPUT_PIN,
        .PRESCALER_RESET_BIT, .COUNT_WR, .COUNT_WDATA, .COMPARE_WR,
        .COMPARE_WDATA, .CONTROL_WR, .CONTROL_WDATA, .COMPARE_IRQ_ENABLE,
        .OVERFLOW_IRQ_ENABLE, .COMPARE_FLAG_CLEAR, .OVERFLOW_FLAG_CLEAR,
        .SLEEP_POWER_SAVE, .SLEEP_POWER_DOWN, .TIMER_COUNT_VALUE,
        .TIMER_COMPARE_VALUE, .TIMER_CONTROL_REG, .COUNT_UPDATE_BUSY,
        .COMPARE_UPDATE_BUSY, .CONTROL_UPDATE_BUSY, .COMPARE_MATCH_FLAG,
        .OVERFLOW_FLAG, .COMPARE_OUTPUT_PIN, .OSC_ENABLE, .OSC_PINS_DETACHED,
        .WAKE_REQUEST, .CPU_STALL, .IRQ_DISPATCH, .REGS_LOST
    );
    ats_osc_model osc (.en(OSC_ENABLE), .osc(OSC_INPUT_PIN));

    always #25 CLK = ~CLK;

    task automatic end_sim();
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask
    // One-cycle strobe on register r: 0 count, 1 compare, 2 control
    task automatic wr(input int r, input logic [7:0] d);
        {COUNT_WR, COMPARE_WR, CONTROL_WR} = 3'h4 >> r;
        {COUNT_WDATA, COMPARE_WDATA, CONTROL_WDATA} = {3{d}};
        cyc(1);
        {COUNT_WR, COMPARE_WR, CONTROL_WR} = 3'h0;
        cyc(1);
    endtask
    task automatic idle();
        for (k = 0; k < 60 && {COUNT_UPDATE_BUSY, COMPARE_UPDATE_BUSY,
             CONTROL_UPDATE_BUSY} !== 3'h0; k++) cyc(1);
        if (k == 60) fail_count++;
    endtask

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        {RESETN, ASYNC_CLOCK_SELECT, PRESCALER_RESET_BIT, COUNT_WR, COMPARE_WR,
         CONTROL_WR, COMPARE_IRQ_ENABLE, OVERFLOW_IRQ_ENABLE,
         COMPARE_FLAG_CLEAR, OVERFLOW_FLAG_CLEAR, SLEEP_POWER_SAVE,
         SLEEP_POWER_DOWN} = 12'h0;
        {COUNT_WDATA, COMPARE_WDATA, CONTROL_WDATA} = 24'h0;
        void'($urandom(32'h26300f48));
        cyc(3);
        RESETN = 1'b1;
        cyc(3);
        chk({TIMER_COUNT_VALUE, TIMER_COMPARE_VALUE, TIMER_CONTROL_REG,
             COUNT_UPDATE_BUSY, OSC_PINS_DETACHED}, 0);
        for (k = 0; k < 4; k++) begin
            d1 = 8'($urandom);
            wr(1, d1);
            chk({COMPARE_UPDATE_BUSY, TIMER_COMPARE_VALUE}, {1'b0, d1});
        end
        // A window of four tap periods holds exactly four ticks; stop holds none over 40 cycles
        for (int c = 0; c < 8; c++) begin
            wr(2, 8'(c));
            cyc(2);
            c0 = TIMER_COUNT_VALUE;
            cyc(c == 0 ? 40 : 4 * divs[c]);
            chk(8'(TIMER_COUNT_VALUE - c0), c == 0 ? 0 : 4);
        end
        wr(2, 8'h02);
        for (k = 0; k < 12; k++) begin
            PRESCALER_RESET_BIT = 1'b1;
            cyc(1);
            PRESCALER_RESET_BIT = 1'b0;
            cyc(3);
            if (k == 0) c0 = TIMER_COUNT_VALUE;
        end
        chk(8'(TIMER_COUNT_VALUE - c0), 0);
        wr(1, 8'h80);
        for (int m = 0; m < 6; m++) begin
            COMPARE_FLAG_CLEAR = 1'b1;
            wr(0, 8'h00);
            COMPARE_FLAG_CLEAR = 1'b0;
            wr(2, {2'h0, modes[m], 4'h1});
            cyc(200);
            chk({COMPARE_MATCH_FLAG, COMPARE_OUTPUT_PIN}, {1'b1, pins[m]});
        end
        // Undivided count from fd must overflow three ticks later
        OVERFLOW_FLAG_CLEAR = 1'b1;
        wr(0, 8'hfd);
        OVERFLOW_FLAG_CLEAR = 1'b0;
        chk(OVERFLOW_FLAG, 0);
        cyc(4);
        chk(OVERFLOW_FLAG, 1);
        {SLEEP_POWER_SAVE, COMPARE_IRQ_ENABLE, OVERFLOW_IRQ_ENABLE} = 3'h0;
        ASYNC_CLOCK_SELECT = 1'b1;
        cyc(30);
        d1 = 8'($urandom);
        d2 = 8'($urandom) & 8'h7f;
        wr(2, 8'h00);
        wr(0, d1);
        wr(1, d2);
        chk({COUNT_UPDATE_BUSY, COMPARE_UPDATE_BUSY, CONTROL_UPDATE_BUSY,
             TIMER_COMPARE_VALUE}, {3'h7, 8'h80});
        idle();
        {COMPARE_FLAG_CLEAR, OVERFLOW_FLAG_CLEAR} = 2'h3;
        cyc(25);
        {COMPARE_FLAG_CLEAR, OVERFLOW_FLAG_CLEAR} = 2'h0;
        chk({TIMER_COUNT_VALUE, TIMER_COMPARE_VALUE}, {d1, d2});
        wr(2, 8'h05);
        chk({CONTROL_UPDATE_BUSY, TIMER_CONTROL_REG}, {1'b1, 8'h00});
        idle();
        chk({CONTROL_UPDATE_BUSY, TIMER_CONTROL_REG}, {1'b0, 8'h05});
        // Wake from power-save on an oscillator-clocked compare match
        wr(2, 8'h01);
        wr(0, 8'h00);
        wr(1, 8'h03);
        idle();
        COMPARE_FLAG_CLEAR = 1'b1;
        cyc(1);
        COMPARE_FLAG_CLEAR = 1'b0;
        chk(COMPARE_MATCH_FLAG, 0);
        {SLEEP_POWER_SAVE, COMPARE_IRQ_ENABLE, OVERFLOW_IRQ_ENABLE} = 3'h7;
        for (k = 0; k < 400 && WAKE_REQUEST !== 1'b1; k++) cyc(1);
        chk(COMPARE_MATCH_FLAG, 1);
        st = 0;
        for (k = 0; k < 20 && IRQ_DISPATCH !== 1'b1; k++) begin
            st += (CPU_STALL === 1'b1);
            cyc(1);
        end
        chk({IRQ_DISPATCH, 8'(st)}, {1'b1, 8'h04});
        {SLEEP_POWER_SAVE, COMPARE_IRQ_ENABLE, OVERFLOW_IRQ_ENABLE} = 3'h0;
        SLEEP_POWER_DOWN = 1'b1;
        cyc(2);
        chk({OSC_ENABLE, OSC_PINS_DETACHED}, 2'h1);
        SLEEP_POWER_DOWN = 1'b0;
        cyc(3);
        chk(REGS_LOST, 1);
        wr(1, 8'h10);
        idle();
        chk({REGS_LOST, TIMER_COMPARE_VALUE}, {1'b0, 8'h10});
        end_sim();
    end
endmodule
